// [pgw_pkg.sv]
// constants and types for the password guarded watchdog
package pgw_pkg;
  localparam logic [7:0] PGW_KEY_WR = 8'h5a;
  localparam logic [7:0] PGW_KEY_RD = 8'h69;
  localparam int PGW_CNT_W = 16;
  // control byte fields
  localparam int PGW_BIT_HOLD = 7;
  localparam int PGW_BIT_NMIES = 6;
  localparam int PGW_BIT_NMISEL = 5;
  localparam int PGW_BIT_TMSEL = 4;
  localparam int PGW_BIT_CLR = 3;
  localparam int PGW_BIT_SSEL = 2;
  localparam int PGW_IS_LO = 0;
  localparam int PGW_IS_HI = 1;
  localparam logic [7:0] PGW_CTL_RST = 8'h00;
  localparam logic [PGW_CNT_W-1:0] PGW_CNT_RST = 16'h0000;
  // tap bit positions for interval selects 0..3
  localparam int PGW_TAP0 = 15;
  localparam int PGW_TAP1 = 13;
  localparam int PGW_TAP2 = 9;
  localparam int PGW_TAP3 = 6;

  typedef struct packed {
    logic [7:0] ctl_r;
    logic [PGW_CNT_W-1:0] cnt_r;
    logic tap_r;
    logic puc_r;
    logic irq_r;
    logic [15:0] rdata_r;
    logic aclk_s1_r;
    logic aclk_s2_r;
    logic aclk_s3_r;
  } pgw_state_t;
endpackage

// [pgw_watchdog.sv]
// password guarded watchdog / interval timer
`timescale 1ns/1ps
// Operation
// - In watchdog mode an unserviced interval expiry raises a system reset.
// - In interval timer mode the expiry raises an interrupt pulse instead of a reset.
// - The counter is a hidden 16-bit up-counter steered by the control byte and also cleared by every power-up-clear restart.
// - The control byte holds seven bits taken from each accepted write; the clear bit is always stored as zero.
// - A write is accepted only when its high byte carries the write key.
// - A write with any other high byte raises a power-up-clear reset.
// - Reads return a fixed high byte different from the write key.
// - Two control bits configure the nmi reset pin function.
module pgw_watchdog (
  input wire logic CLK_I,
  input wire logic NRST_I,
  input wire logic WR_I,
  input wire logic RD_I,
  input wire logic [15:0] WDATA_I,
  input wire logic ACLK_I,
  output logic [15:0] RDATA_O,
  output logic PUC_O,
  output logic IRQ_O,
  output logic NMI_SEL_O,
  output logic NMI_EDGE_O
);
  import pgw_pkg::*;

  // whole block state lives in one registered struct
  pgw_state_t s_r;
  pgw_state_t s_nxt;

  // count source selection
  logic aclk_rise;
  logic src_aux;
  logic tick;
  logic held;
  logic cnt_step;
  logic [PGW_CNT_W-1:0] cnt_inc;

  // interval selection and expiry
  logic [1:0] isel;
  logic tap;
  logic tap_fall;
  logic mode_timer;
  logic exp_irq;
  logic exp_puc;

  // write decode
  logic [7:0] wr_key;
  logic [7:0] wr_byte;
  logic key_ok;
  logic wr_good;
  logic wr_bad;
  logic wr_clear;
  logic [7:0] ctl_wr;

  // read path
  logic [15:0] rd_word;

  // restart after any power-up-clear pulse
  logic restart;

  // aux clock: two sync flops, the third only feeds the edge detect
  assign aclk_rise = s_r.aclk_s2_r & ~s_r.aclk_s3_r;

  assign src_aux = s_r.ctl_r[PGW_BIT_SSEL];

  assign tick = src_aux ? aclk_rise : 1'b1;

  assign held = s_r.ctl_r[PGW_BIT_HOLD];

  assign cnt_step = tick & ~held;

  // wraps silently; expiry comes from the tap, not from the carry
  assign cnt_inc = s_r.cnt_r + 16'h0001;

  assign isel = s_r.ctl_r[PGW_IS_HI:PGW_IS_LO];

  always_comb begin
    case (isel)
      2'h0: begin
        tap = s_r.cnt_r[PGW_TAP0];
      end
      2'h1: begin
        tap = s_r.cnt_r[PGW_TAP1];
      end
      2'h2: begin
        tap = s_r.cnt_r[PGW_TAP2];
      end
      default: begin
        tap = s_r.cnt_r[PGW_TAP3];
      end
    endcase
  end

  // expiry is the falling edge of the chosen tap, so the first one
  // after a clear comes at twice the tap weight
  assign tap_fall = s_r.tap_r & ~tap;

  assign mode_timer = s_r.ctl_r[PGW_BIT_TMSEL];

  assign exp_irq = tap_fall & mode_timer;

  assign exp_puc = tap_fall & ~mode_timer;

  assign wr_key = WDATA_I[15:8];

  assign wr_byte = WDATA_I[7:0];

  assign key_ok = (wr_key == PGW_KEY_WR);

  assign wr_good = WR_I & key_ok;

  assign wr_bad = WR_I & ~key_ok;

  assign wr_clear = wr_good & wr_byte[PGW_BIT_CLR];

  // clear bit is a strobe and never reads back as set
  always_comb begin
    ctl_wr = wr_byte;
    ctl_wr[PGW_BIT_CLR] = 1'b0;
  end

  // read key differs from write key so a blind read-modify-write traps
  assign rd_word = {PGW_KEY_RD, s_r.ctl_r};

  assign restart = s_r.puc_r;

  always_comb begin
    s_nxt = s_r;

    // pulses last one cycle unless set again below
    s_nxt.puc_r = 1'b0;
    s_nxt.irq_r = 1'b0;

    s_nxt.aclk_s1_r = ACLK_I;
    s_nxt.aclk_s2_r = s_r.aclk_s1_r;
    s_nxt.aclk_s3_r = s_r.aclk_s2_r;

    if (cnt_step) begin
      s_nxt.cnt_r = cnt_inc;
    end

    s_nxt.tap_r = tap;

    if (exp_irq) begin
      s_nxt.irq_r = 1'b1;
    end

    if (exp_puc) begin
      s_nxt.puc_r = 1'b1;
    end

    if (wr_good) begin
      s_nxt.ctl_r = ctl_wr;
    end

    // service wins over an expiry in the same cycle
    if (wr_clear) begin
      s_nxt.cnt_r = PGW_CNT_RST;
      s_nxt.tap_r = 1'b0;
      s_nxt.irq_r = 1'b0;
      s_nxt.puc_r = 1'b0;
    end

    if (wr_bad) begin
      s_nxt.puc_r = 1'b1;
    end

    if (RD_I) begin
      s_nxt.rdata_r = rd_word;
    end

    // restart one cycle late so the pulse itself stays visible
    if (restart) begin
      s_nxt.ctl_r = PGW_CTL_RST;
      s_nxt.cnt_r = PGW_CNT_RST;
      s_nxt.tap_r = 1'b0;
      s_nxt.irq_r = 1'b0;
      s_nxt.puc_r = 1'b0;
    end
  end

  always_ff @(posedge CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign RDATA_O = s_r.rdata_r;

  assign PUC_O = s_r.puc_r;

  assign IRQ_O = s_r.irq_r;

  assign NMI_SEL_O = s_r.ctl_r[PGW_BIT_NMISEL];

  assign NMI_EDGE_O = s_r.ctl_r[PGW_BIT_NMIES];

  // rdata is left alone by a restart; the control byte, counter, tap and pulse flops
  // go back to their power-up values
endmodule // pgw_watchdog

// [pgw_checker.sv]
// assertions for the guarded watchdog
`timescale 1ns/1ps
module pgw_checker (
  input wire logic CLK_I,
  input wire logic NRST_I,
  input wire logic WR_I,
  input wire logic RD_I,
  input wire logic ACLK_I,
  input wire logic PUC_O,
  input wire logic IRQ_O,
  input wire logic NMI_SEL_O,
  input wire logic NMI_EDGE_O,
  input wire logic [15:0] WDATA_I,
  input wire logic [15:0] RDATA_O
);
  default clocking @(posedge CLK_I); endclocking
  default disable iff (!NRST_I);
  wire logic kw = WR_I && WDATA_I[15:8] == 8'h5a;
  bad_key_a: assert property (WR_I && !kw |=> PUC_O) else $error("no puc");
  rd_key_a: assert property (RD_I |=> RDATA_O[15:8] == 8'h69) else $error("rd key");
  rd_byte_a: assert property (kw ##2 RD_I |=>
    RDATA_O[7:0] == ($past(WDATA_I[7:0], 3) & 8'hf7)) else $error("rd byte");
  nmi_cfg_a: assert property (kw |-> ##2 NMI_SEL_O == $past(WDATA_I[5], 2) &&
    NMI_EDGE_O == $past(WDATA_I[6], 2)) else $error("nmi cfg");
  rst_cfg_a: assert property (PUC_O |-> ##2 !NMI_SEL_O) else $error("puc cfg");
  puc_one_a: assert property (PUC_O |=> !PUC_O) else $error("puc len");
  wd_exp_a: assert property (kw && WDATA_I[7:0] == 8'h0b |->
    !IRQ_O throughout ##[125:132] PUC_O) else $error("wd exp");
  tm_irq_a: assert property (kw && WDATA_I[7:0] == 8'h1b |->
    !PUC_O throughout ##[125:132] IRQ_O) else $error("tm irq");
  cover property (PUC_O);
  cover property (IRQ_O);
  cover property (RD_I);
endmodule // pgw_checker
bind pgw_watchdog pgw_checker pgw_checker_inst (.*);

// [tb.sv]
// self-checking bench for the guarded watchdog
`timescale 1ns/1ps
module tb;
  logic CLK_I = 0, NRST_I = 0, WR_I = 0, RD_I = 0, ACLK_I = 0;
  logic [15:0] WDATA_I = 16'h0000;
  logic [15:0] RDATA_O;
  logic PUC_O, IRQ_O, NMI_SEL_O, NMI_EDGE_O;
  int err_count = 0, samples_checked = 0, n;
  logic aclk_run = 0;
  always @(posedge CLK_I) if (aclk_run) ACLK_I <= ~ACLK_I;
  pgw_watchdog pgw_watchdog_inst (.*);
  always #50 CLK_I = ~CLK_I;
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [15:0] d);
    @(posedge CLK_I); WR_I <= 1'b1; WDATA_I <= d;
    @(posedge CLK_I); WR_I <= 1'b0; #1;
  endtask
  task automatic rd;
    @(posedge CLK_I); RD_I <= 1'b1;
    @(posedge CLK_I); RD_I <= 1'b0; #1;
  endtask
  // bounded wait on the pulse; n counts edges since the write
  task automatic wt(input bit irq, input int lo, input int hi);
    n = 0;
    while (n < 300 && (irq ? IRQ_O : PUC_O) !== 1'b1) begin
      @(posedge CLK_I); #1; n++;
    end
    chk({15'h0, n >= lo && n <= hi}, 16'h1);
  endtask
  task automatic t_rw;
    wr(16'h5a6b); rd;
    chk(RDATA_O, 16'h6963);
    chk({14'h0, NMI_EDGE_O, NMI_SEL_O}, 16'h3);
    $display("rw done");
  endtask
  task automatic t_wd;
    wr(16'h5a0b); wt(0, 125, 132);
    repeat (2) @(posedge CLK_I);
    rd; chk(RDATA_O, 16'h6900);
    $display("wd done");
  endtask
  task automatic t_tm;
    wr(16'h5a1b); wt(1, 125, 132);
    $display("tm done");
  endtask
  task automatic t_hold;
    wr(16'h5a8b); wt(0, 300, 300);
    $display("hold done");
  endtask
  task automatic t_aclk;
    aclk_run <= 1'b1;
    wr(16'h5a1f); wt(1, 250, 264);
    aclk_run <= 1'b0;
    $display("aclk done");
  endtask
  task automatic t_bad;
    wr(16'h1200); chk({15'h0, PUC_O}, 16'h1);
    $display("bad done");
  endtask
  task tally_and_finish;
    $display("checks %0d errors %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial begin
    repeat (6) @(posedge CLK_I);
    NRST_I <= 1'b1;
    t_rw; t_wd; t_tm; t_hold; t_aclk; t_bad;
    tally_and_finish;
  end
  initial begin
    #200000; err_count++; tally_and_finish;
  end
endmodule // tb
